// ==== verilog/lpdr_pkg.sv ====
// Constants and types of the LCD shade table and dither pattern register bank
package lpdr_pkg;
  localparam logic [31:0] LPDR_ADDR_RED = 32'h01F0_0014;
  localparam logic [31:0] LPDR_ADDR_GREEN = 32'h01F0_0018;
  localparam logic [31:0] LPDR_ADDR_BLUE = 32'h01F0_001C;
  localparam logic [31:0] LPDR_ADDR_D12 = 32'h01F0_0020;
  localparam logic [31:0] LPDR_ADDR_D47 = 32'h01F0_0024;
  localparam logic [31:0] LPDR_ADDR_D35 = 32'h01F0_0028;
  localparam logic [31:0] LPDR_ADDR_D23 = 32'h01F0_002C;
  localparam logic [31:0] LPDR_ADDR_D57 = 32'h01F0_0030;
  localparam logic [31:0] LPDR_ADDR_D34 = 32'h01F0_0034;
  localparam logic [31:0] LPDR_ADDR_D45 = 32'h01F0_0038;
  localparam logic [31:0] LPDR_ADDR_CTRL = 32'h01F0_0040;

  localparam logic [31:0] LPDR_RST_RED = 32'h0000_0000;
  localparam logic [31:0] LPDR_RST_GREEN = 32'h0000_0000;
  localparam logic [15:0] LPDR_RST_BLUE = 16'h0000;
  localparam logic [15:0] LPDR_RST_D12 = 16'hA5A5;
  localparam logic [27:0] LPDR_RST_D47 = 28'hBA5_DA65;
  localparam logic [19:0] LPDR_RST_D35 = 20'hA_5A5F;
  localparam logic [11:0] LPDR_RST_D23 = 12'hD6B;
  localparam logic [27:0] LPDR_RST_D57 = 28'hEB7_B5ED;
  localparam logic [15:0] LPDR_RST_D34 = 16'h7DBE;
  localparam logic [19:0] LPDR_RST_D45 = 20'h7_EBDF;
  localparam logic [1:0] LPDR_RST_DTYPE = 2'h0;

  // Control register layout
  localparam int LPDR_DTYPE_HI = 28;
  localparam int LPDR_DTYPE_LO = 27;
  localparam int LPDR_FNUM_HI = 3;
  localparam int LPDR_FNUM_LO = 0;

  localparam logic [1:0] LPDR_MODE_MONO = 2'h0;
  localparam logic [1:0] LPDR_MODE_GRAY4 = 2'h1;
  localparam logic [1:0] LPDR_MODE_GRAY16 = 2'h2;
  localparam logic [1:0] LPDR_MODE_COLOR = 2'h3;

  // Pattern periods in frames; each pattern holds four rows of one period
  localparam logic [2:0] LPDR_PER3 = 3'h3;
  localparam logic [2:0] LPDR_PER4 = 3'h4;
  localparam logic [2:0] LPDR_PER5 = 3'h5;
  localparam logic [2:0] LPDR_PER7 = 3'h7;

  localparam logic [3:0] LPDR_LVL_MAX = 4'hF;
  localparam logic [3:0] LPDR_LVL_MID = 4'h8;
  localparam logic [3:0] LPDR_LVL_LOW = 4'h7;

  typedef enum logic [3:0] {
    LPDR_SEL_RED, LPDR_SEL_GREEN, LPDR_SEL_BLUE, LPDR_SEL_D12, LPDR_SEL_D47, LPDR_SEL_D35,
    LPDR_SEL_D23, LPDR_SEL_D57, LPDR_SEL_D34, LPDR_SEL_D45, LPDR_SEL_CTRL, LPDR_SEL_NONE
  } lpdr_sel_t;
endpackage : lpdr_pkg

// ==== verilog/lpdr_frc_if.sv ====
// Carrier between the register bank and the frame rate gray control
`timescale 1ns/1ps
interface lpdr_frc_if;
  logic [15:0] d12;
  logic [27:0] d47;
  logic [19:0] d35;
  logic [11:0] d23;
  logic [27:0] d57;
  logic [15:0] d34;
  logic [19:0] d45;
  logic frame_tick;
  logic [1:0] row;
  logic [1:0] col;
  logic [3:0] lvl_r;
  logic [3:0] lvl_g;
  logic [3:0] lvl_b;
  logic on_r;
  logic on_g;
  logic on_b;
  logic [3:0] fnum;
  modport regs (output d12, d47, d35, d23, d57, d34, d45, frame_tick, row, col, lvl_r, lvl_g, lvl_b,
                input on_r, on_g, on_b, fnum);
  modport frc (input d12, d47, d35, d23, d57, d34, d45, frame_tick, row, col, lvl_r, lvl_g, lvl_b,
               output on_r, on_g, on_b, fnum);
endinterface : lpdr_frc_if

// ==== verilog/lpdr_frc.sv ====
// Frame rate gray control: turns a 4-bit shade level into a per-frame dot
`timescale 1ns/1ps
module lpdr_frc import lpdr_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  lpdr_frc_if.frc fi
);
  typedef struct packed {
    logic [2:0] c3;
    logic [2:0] c4;
    logic [2:0] c5;
    logic [2:0] c7;
    logic [3:0] fnum;
  } lpdr_frc_st_t;

  lpdr_frc_st_t st_reg;
  lpdr_frc_st_t st_next;
  logic [6:0] duty;

  function automatic logic [2:0] lpdr_wrap(input logic [2:0] cnt, input logic [1:0] col, input logic [2:0] per);
    logic [3:0] s;
    s = {1'b0, cnt} + {2'h0, col};
    if (s >= {1'b0, per}) begin
      s = s - {1'b0, per};
    end
    return s[2:0];
  endfunction : lpdr_wrap

  function automatic logic lpdr_pick(input logic [27:0] pat, input logic [1:0] row, input logic [2:0] ph,
                                     input logic [2:0] per);
    logic [4:0] idx;
    idx = 5'(row * per) + {2'h0, ph};
    return pat[idx];
  endfunction : lpdr_pick

  // Levels from mid to 14 use a pattern, levels 1 to 7 use its complement; 15 is always on, 0 always off
  function automatic logic lpdr_level_on(input logic [3:0] lvl, input logic [6:0] d);
    logic [3:0] k;
    logic r;
    k = 4'h0;
    r = 1'b0;
    if (lvl == LPDR_LVL_MAX) begin
      r = 1'b1;
    end else if (lvl >= LPDR_LVL_MID) begin
      k = lvl - LPDR_LVL_MID;
      r = d[k[2:0]];
    end else if (lvl != 4'h0) begin
      k = LPDR_LVL_LOW - lvl;
      r = ~d[k[2:0]];
    end
    return r;
  endfunction : lpdr_level_on

  always_comb begin
    st_next = st_reg;
    if (fi.frame_tick) begin
      st_next.c3 = (st_reg.c3 == LPDR_PER3 - 3'h1) ? 3'h0 : st_reg.c3 + 3'h1;
      st_next.c4 = (st_reg.c4 == LPDR_PER4 - 3'h1) ? 3'h0 : st_reg.c4 + 3'h1;
      st_next.c5 = (st_reg.c5 == LPDR_PER5 - 3'h1) ? 3'h0 : st_reg.c5 + 3'h1;
      st_next.c7 = (st_reg.c7 == LPDR_PER7 - 3'h1) ? 3'h0 : st_reg.c7 + 3'h1;
      st_next.fnum = st_reg.fnum + 4'h1;
    end
  end

  // Column shifts the frame phase so neighbouring dots do not flash together
  always_comb begin
    duty[0] = lpdr_pick({12'h000, fi.d12}, fi.row, lpdr_wrap(st_reg.c4, fi.col, LPDR_PER4), LPDR_PER4);
    duty[1] = lpdr_pick(fi.d47, fi.row, lpdr_wrap(st_reg.c7, fi.col, LPDR_PER7), LPDR_PER7);
    duty[2] = lpdr_pick({8'h00, fi.d35}, fi.row, lpdr_wrap(st_reg.c5, fi.col, LPDR_PER5), LPDR_PER5);
    duty[3] = lpdr_pick({16'h0000, fi.d23}, fi.row, lpdr_wrap(st_reg.c3, fi.col, LPDR_PER3), LPDR_PER3);
    duty[4] = lpdr_pick(fi.d57, fi.row, lpdr_wrap(st_reg.c7, fi.col, LPDR_PER7), LPDR_PER7);
    duty[5] = lpdr_pick({12'h000, fi.d34}, fi.row, lpdr_wrap(st_reg.c4, fi.col, LPDR_PER4), LPDR_PER4);
    duty[6] = lpdr_pick({8'h00, fi.d45}, fi.row, lpdr_wrap(st_reg.c5, fi.col, LPDR_PER5), LPDR_PER5);
  end

  assign fi.on_r = lpdr_level_on(fi.lvl_r, duty);
  assign fi.on_g = lpdr_level_on(fi.lvl_g, duty);
  assign fi.on_b = lpdr_level_on(fi.lvl_b, duty);
  assign fi.fnum = st_reg.fnum;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : lpdr_frc

// ==== verilog/lpdr_regs.sv ====
// LCD shade tables and dither patterns: AHB-Lite slave and pixel shade lookup
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module lpdr_regs import lpdr_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic frame_start,
  input wire logic pix_valid,
  input wire logic [7:0] pix_code,
  input wire logic [1:0] pix_row,
  input wire logic [1:0] pix_col,
  output logic pix_out_valid,
  output logic [3:0] red_shade,
  output logic [3:0] green_shade,
  output logic [3:0] blue_shade,
  output logic red_dot,
  output logic green_dot,
  output logic blue_dot
);
  typedef struct packed {
    logic [31:0] red;
    logic [31:0] green;
    logic [15:0] blue;
    logic [15:0] d12;
    logic [27:0] d47;
    logic [19:0] d35;
    logic [11:0] d23;
    logic [27:0] d57;
    logic [15:0] d34;
    logic [19:0] d45;
    logic [1:0] dtype;
    logic dp_act;
    logic dp_wr;
    logic rd_pend;
    lpdr_sel_t sel;
    logic [31:0] rdata;
    logic pv;
    logic [3:0] sr;
    logic [3:0] sg;
    logic [3:0] sb;
    logic dr;
    logic dg;
    logic db;
  } lpdr_st_t;

  lpdr_st_t st_reg;
  lpdr_st_t st_next;
  lpdr_frc_if fi ();
  logic [3:0] lvl_r;
  logic [3:0] lvl_g;
  logic [3:0] lvl_b;

  function automatic lpdr_sel_t lpdr_decode(input logic [31:0] a);
    lpdr_sel_t s;
    if (a == LPDR_ADDR_RED) begin
      s = LPDR_SEL_RED;
    end else if (a == LPDR_ADDR_GREEN) begin
      s = LPDR_SEL_GREEN;
    end else if (a == LPDR_ADDR_BLUE) begin
      s = LPDR_SEL_BLUE;
    end else if (a == LPDR_ADDR_D12) begin
      s = LPDR_SEL_D12;
    end else if (a == LPDR_ADDR_D47) begin
      s = LPDR_SEL_D47;
    end else if (a == LPDR_ADDR_D35) begin
      s = LPDR_SEL_D35;
    end else if (a == LPDR_ADDR_D23) begin
      s = LPDR_SEL_D23;
    end else if (a == LPDR_ADDR_D57) begin
      s = LPDR_SEL_D57;
    end else if (a == LPDR_ADDR_D34) begin
      s = LPDR_SEL_D34;
    end else if (a == LPDR_ADDR_D45) begin
      s = LPDR_SEL_D45;
    end else if (a == LPDR_ADDR_CTRL) begin
      s = LPDR_SEL_CTRL;
    end else begin
      s = LPDR_SEL_NONE;
    end
    return s;
  endfunction : lpdr_decode

  // Code n picks nibble [4n+3:4n] of a shade table
  function automatic logic [3:0] lpdr_nibble(input logic [31:0] tbl, input logic [2:0] n);
    return tbl[{n, 2'b00} +: 4];
  endfunction : lpdr_nibble

  always_comb begin
    lvl_r = 4'h0;
    lvl_g = 4'h0;
    lvl_b = 4'h0;
    case (st_reg.dtype)
      LPDR_MODE_COLOR: begin
        lvl_r = lpdr_nibble(st_reg.red, pix_code[7:5]);
        lvl_g = lpdr_nibble(st_reg.green, pix_code[4:2]);
        lvl_b = lpdr_nibble({16'h0000, st_reg.blue}, {1'b0, pix_code[1:0]});
      end
      LPDR_MODE_GRAY16: begin
        lvl_r = pix_code[3:0];
        lvl_g = pix_code[3:0];
        lvl_b = pix_code[3:0];
      end
      LPDR_MODE_GRAY4: begin
        // Four gray levels reuse the blue table as their shade map
        lvl_r = lpdr_nibble({16'h0000, st_reg.blue}, {1'b0, pix_code[1:0]});
        lvl_g = lvl_r;
        lvl_b = lvl_r;
      end
      default: begin
        lvl_r = pix_code[0] ? LPDR_LVL_MAX : 4'h0;
        lvl_g = lvl_r;
        lvl_b = lvl_r;
      end
    endcase
  end

  assign fi.d12 = st_reg.d12;
  assign fi.d47 = st_reg.d47;
  assign fi.d35 = st_reg.d35;
  assign fi.d23 = st_reg.d23;
  assign fi.d57 = st_reg.d57;
  assign fi.d34 = st_reg.d34;
  assign fi.d45 = st_reg.d45;
  assign fi.frame_tick = frame_start;
  assign fi.row = pix_row;
  assign fi.col = pix_col;
  assign fi.lvl_r = lvl_r;
  assign fi.lvl_g = lvl_g;
  assign fi.lvl_b = lvl_b;

  lpdr_frc u_frc (
    .hclk(hclk),
    .hresetn(hresetn),
    .fi(fi)
  );

  always_comb begin
    st_next = st_reg;
    // Write data phase; unmapped addresses are ignored but still answered OKAY
    if (st_reg.dp_act && st_reg.dp_wr) begin
      st_next.dp_act = 1'b0;
      case (st_reg.sel)
        LPDR_SEL_RED: st_next.red = hwdata;
        LPDR_SEL_GREEN: st_next.green = hwdata;
        LPDR_SEL_BLUE: st_next.blue = hwdata[15:0];
        LPDR_SEL_D12: st_next.d12 = hwdata[15:0];
        LPDR_SEL_D47: st_next.d47 = hwdata[27:0];
        LPDR_SEL_D35: st_next.d35 = hwdata[19:0];
        LPDR_SEL_D23: st_next.d23 = hwdata[11:0];
        LPDR_SEL_D57: st_next.d57 = hwdata[27:0];
        LPDR_SEL_D34: st_next.d34 = hwdata[15:0];
        LPDR_SEL_D45: st_next.d45 = hwdata[19:0];
        LPDR_SEL_CTRL: st_next.dtype = hwdata[LPDR_DTYPE_HI:LPDR_DTYPE_LO];
        default: st_next.dtype = st_reg.dtype;
      endcase
    end
    // Reads take one wait state so that hrdata comes straight from a flip-flop
    if (st_reg.dp_act && !st_reg.dp_wr) begin
      if (st_reg.rd_pend) begin
        st_next.rd_pend = 1'b0;
        st_next.rdata = 32'h0000_0000;
        case (st_reg.sel)
          LPDR_SEL_RED: st_next.rdata = st_reg.red;
          LPDR_SEL_GREEN: st_next.rdata = st_reg.green;
          LPDR_SEL_BLUE: st_next.rdata[15:0] = st_reg.blue;
          LPDR_SEL_D12: st_next.rdata[15:0] = st_reg.d12;
          LPDR_SEL_D47: st_next.rdata[27:0] = st_reg.d47;
          LPDR_SEL_D35: st_next.rdata[19:0] = st_reg.d35;
          LPDR_SEL_D23: st_next.rdata[11:0] = st_reg.d23;
          LPDR_SEL_D57: st_next.rdata[27:0] = st_reg.d57;
          LPDR_SEL_D34: st_next.rdata[15:0] = st_reg.d34;
          LPDR_SEL_D45: st_next.rdata[19:0] = st_reg.d45;
          LPDR_SEL_CTRL: begin
            st_next.rdata[LPDR_DTYPE_HI:LPDR_DTYPE_LO] = st_reg.dtype;
            st_next.rdata[LPDR_FNUM_HI:LPDR_FNUM_LO] = fi.fnum;
          end
          default: st_next.rdata = 32'h0000_0000;
        endcase
      end else begin
        st_next.dp_act = 1'b0;
      end
    end
    // Address phase, sampled only while the bus is ready
    if (hsel && htrans[1] && hready) begin
      st_next.dp_act = 1'b1;
      st_next.dp_wr = hwrite;
      st_next.rd_pend = !hwrite;
      st_next.sel = lpdr_decode(haddr);
    end
    st_next.pv = pix_valid;
    if (pix_valid) begin
      st_next.sr = lvl_r;
      st_next.sg = lvl_g;
      st_next.sb = lvl_b;
      st_next.dr = fi.on_r;
      st_next.dg = fi.on_g;
      st_next.db = fi.on_b;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.red <= LPDR_RST_RED;
      st_reg.green <= LPDR_RST_GREEN;
      st_reg.blue <= LPDR_RST_BLUE;
      st_reg.d12 <= LPDR_RST_D12;
      st_reg.d47 <= LPDR_RST_D47;
      st_reg.d35 <= LPDR_RST_D35;
      st_reg.d23 <= LPDR_RST_D23;
      st_reg.d57 <= LPDR_RST_D57;
      st_reg.d34 <= LPDR_RST_D34;
      st_reg.d45 <= LPDR_RST_D45;
      st_reg.dtype <= LPDR_RST_DTYPE;
      st_reg.sel <= LPDR_SEL_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hreadyout = !(st_reg.dp_act && !st_reg.dp_wr && st_reg.rd_pend);
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign pix_out_valid = st_reg.pv;
  assign red_shade = st_reg.sr;
  assign green_shade = st_reg.sg;
  assign blue_shade = st_reg.sb;
  assign red_dot = st_reg.dr;
  assign green_dot = st_reg.dg;
  assign blue_dot = st_reg.db;
endmodule : lpdr_regs

// ==== testbench/lpdr_regs_checker.sv ====
// Bus and pixel timing assertions for the shade and dither register bank
`timescale 1ns/1ps
module lpdr_regs_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic pix_valid,
  input wire logic pix_out_valid,
  input wire logic [3:0] red_shade,
  input wire logic [3:0] green_shade,
  input wire logic [3:0] blue_shade,
  input wire logic red_dot,
  input wire logic green_dot,
  input wire logic blue_dot
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign wr_take = hsel && htrans[1] && hready && hwrite;
  AST_READ_ONE_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  AST_WRITE_NO_WAIT: assert property (wr_take |=> hreadyout) else $error("write stalled");
  AST_WAIT_CAUSE: assert property ($fell(hreadyout) |-> $past(rd_take)) else $error("stray wait");
  AST_OKAY: assert property (hresp == 1'b0) else $error("response not okay");
  AST_RDATA_HOLD: assert property (!$stable(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
  AST_PIX_LATENCY: assert property (pix_valid |=> pix_out_valid) else $error("pixel result late");
  AST_PIX_SINGLE: assert property (!pix_valid |=> !pix_out_valid) else $error("stray pixel result");
  AST_SHADE_HOLD: assert property (!pix_valid |=> $stable({red_shade, green_shade, blue_shade, red_dot,
    green_dot, blue_dot})) else $error("pixel outputs moved");
  AST_DOT_EXTREMES: assert property (pix_out_valid |-> (red_shade != 4'hF || red_dot) &&
    (red_shade != 4'h0 || !red_dot)) else $error("full or zero level dot wrong");
  cover property (rd_take ##2 hrdata != 32'h0);
  cover property (wr_take);
  cover property (pix_valid ##1 red_dot);
endmodule : lpdr_regs_checker

// ==== testbench/lpdr_regs_tb.sv ====
// Self-checking bench for the shade and dither register bank
`timescale 1ns/1ps
module lpdr_regs_tb import lpdr_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, pix_valid, frame_start;
  logic [31:0] haddr, hwdata, r;
  logic [1:0] htrans, pix_row, pix_col;
  logic [2:0] hsize;
  logic [7:0] pix_code;
  wire logic hreadyout, hresp, pix_out_valid, red_dot, green_dot, blue_dot;
  wire logic [31:0] hrdata;
  wire logic [3:0] red_shade, green_shade, blue_shade;
  int failures, checks, cyc;
  logic [31:0] ra [10] = '{LPDR_ADDR_RED, LPDR_ADDR_GREEN, LPDR_ADDR_BLUE, LPDR_ADDR_D12, LPDR_ADDR_D47,
    LPDR_ADDR_D35, LPDR_ADDR_D23, LPDR_ADDR_D57, LPDR_ADDR_D34, LPDR_ADDR_D45};
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'hA5A5, 32'hBA5DA65, 32'hA5A5F, 32'hD6B, 32'hEB7B5ED,
    32'h7DBE, 32'h7EBDF};
  logic [31:0] rm [10] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFFFFF, 32'hFFFFF, 32'hFFF,
    32'hFFFFFFF, 32'hFFFF, 32'hFFFFF};
  int per [7] = '{4, 7, 5, 3, 7, 4, 5};
  int pop [7] = '{8, 16, 12, 8, 20, 12, 16};

  lpdr_regs lpdr_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .frame_start(frame_start), .pix_valid(pix_valid), .pix_code(pix_code),
    .pix_row(pix_row), .pix_col(pix_col), .pix_out_valid(pix_out_valid), .red_shade(red_shade),
    .green_shade(green_shade), .blue_shade(blue_shade), .red_dot(red_dot), .green_dot(green_dot),
    .blue_dot(blue_dot));

  initial begin
    hclk = 0;
    forever #50 hclk = ~hclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk iff hreadyout === 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hreadyout === 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic px(input logic [7:0] c, input logic [1:0] row, input logic [1:0] col);
    @(posedge hclk);
    pix_valid <= 1'b1;
    pix_code <= c;
    pix_row <= row;
    pix_col <= col;
    @(posedge hclk);
    pix_valid <= 1'b0;
    #1;
  endtask : px

  task automatic t_regs;
    for (int i = 0; i < 10; i++) begin
      ahb(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], r);
      ahb(1'b1, ra[i], 32'hFFFFFFFF);
      ahb(1'b0, ra[i], 32'h0);
      chk("all ones", rm[i], r);
      ahb(1'b1, ra[i], rv[i] ^ 32'h5A5A5A5A);
      ahb(1'b0, ra[i], 32'h0);
      chk("pattern", (rv[i] ^ 32'h5A5A5A5A) & rm[i], r);
      ahb(1'b1, ra[i], rv[i]);
    end
    ahb(1'b1, 32'h01F0_0100, 32'hFFFFFFFF);
    ahb(1'b0, 32'h01F0_0100, 32'h0);
    chk("unmapped", 32'h0, r);
    $display("test registers done");
  endtask : t_regs

  task automatic t_color;
    ahb(1'b1, LPDR_ADDR_CTRL, 32'h1800_0000);
    ahb(1'b1, LPDR_ADDR_RED, 32'hFEDC_BA98);
    ahb(1'b1, LPDR_ADDR_GREEN, 32'h7654_3210);
    ahb(1'b1, LPDR_ADDR_BLUE, 32'h5A3C);
    for (int n = 0; n < 8; n++) begin
      px({n[2:0], ~n[2:0], n[1:0]}, 2'h0, 2'h0);
      chk("red", 32'hFEDCBA98 >> (4 * n) & 32'hF, {28'h0, red_shade});
      chk("green", 32'h76543210 >> (4 * (7 - n)) & 32'hF, {28'h0, green_shade});
      chk("blue", 32'h5A3C >> (4 * n[1:0]) & 32'hF, {28'h0, blue_shade});
    end
    ahb(1'b1, LPDR_ADDR_CTRL, 32'h0);
    px(8'h01, 2'h0, 2'h0);
    chk("mono on", 32'hF, {28'h0, red_shade});
    px(8'hFE, 2'h0, 2'h0);
    chk("mono off", 32'h0, {28'h0, red_shade});
    ahb(1'b1, LPDR_ADDR_CTRL, 32'h0800_0000);
    px(8'h02, 2'h0, 2'h0);
    chk("four gray", 32'hA, {28'h0, green_shade});
    $display("test color and modes done");
  endtask : t_color

  task automatic t_duty;
    int i, p, e, on, ong, onb, fr;
    ahb(1'b1, LPDR_ADDR_CTRL, 32'h1000_0000);
    fr = 0;
    for (int lv = 0; lv < 16; lv++) begin
      i = lv >= 8 ? lv - 8 : 7 - lv;
      p = (lv == 0 || lv == 15) ? 4 : per[i];
      e = lv == 15 ? 16 : lv == 0 ? 0 : lv >= 8 ? pop[i] : 4 * p - pop[i];
      on = 0;
      ong = 0;
      onb = 0;
      for (int f = 0; f < p; f++) begin
        for (int row = 0; row < 4; row++) begin
          // A fixed column offset still visits every phase once over a full period
          px(lv[7:0], row[1:0], lv[1:0]);
          chk("gray level", lv, {28'h0, blue_shade});
          on += int'(red_dot === 1'b1);
          ong += int'(green_dot === 1'b1);
          onb += int'(blue_dot === 1'b1);
        end
        @(posedge hclk);
        frame_start <= 1'b1;
        @(posedge hclk);
        frame_start <= 1'b0;
        fr++;
      end
      chk("duty", e, on);
      chk("green duty", e, ong);
      chk("blue duty", e, onb);
    end
    ahb(1'b0, LPDR_ADDR_CTRL, 32'h0);
    chk("control", 32'h1000_0000 | (fr % 16), r);
    $display("test duty done");
  endtask : t_duty

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, pix_valid, frame_start, htrans, pix_row, pix_col, pix_code} = '0;
    {haddr, hwdata, failures, checks, cyc} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_color();
    t_duty();
    wrap_up();
  end
endmodule : lpdr_regs_tb

bind lpdr_regs lpdr_regs_checker lpdr_regs_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pix_valid(pix_valid), .pix_out_valid(pix_out_valid), .red_shade(red_shade), .green_shade(green_shade),
  .blue_shade(blue_shade), .red_dot(red_dot), .green_dot(green_dot), .blue_dot(blue_dot));
